/* File: hdl/spcc_port.sv */
// Functional notes
// (RULE_01) Reset clears the configuration and clock divider registers to zero.
// (RULE_02) Polarity bit one makes falling edge active; zero makes rising edge active.
// (RULE_03) Phase bit one samples on inactive edge; zero samples on active edge.
// (RULE_04) Character length bit selects eight bits at zero, sixteen at one.
// (RULE_05) Configuration bits five to three are reserved and read zero.
// (RULE_06) Select level bit zero means select is active low; one, active high.
// (RULE_07) Interrupt enable lets any of the four status flags request an interrupt.
// (RULE_08) Master clock runs at half system clock over divide ratio plus one.
// (RULE_09) In slave mode the divider has no effect and clock generation stops.
// (RULE_10) Interrupt request is enable AND the OR of the flags, held as a level.
//
// Decided for this implementation: the APB register port.
module spcc_port #(
	parameter int BUF_DEPTH = 2
) (
	input  wire logic                            clk,
	input  wire logic                            rst_n,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [spcc_pkg::SPCC_AW-1:0]    paddr,
	input  wire logic [spcc_pkg::SPCC_DW-1:0]    pwdata,
	output      logic [spcc_pkg::SPCC_DW-1:0]    prdata,
	output      logic                            pready,
	output      logic                            pslverr,
	input  wire logic                            sclk_i,
	output      logic                            sclk_o,
	output      logic                            sclk_oe,
	input  wire logic                            mosi_i,
	output      logic                            mosi_o,
	output      logic                            mosi_oe,
	input  wire logic                            miso_i,
	output      logic                            miso_o,
	output      logic                            miso_oe,
	input  wire logic                            ssel_i,
	output      logic                            port_irq
);
	import spcc_pkg::*;

	typedef struct packed {
		logic [7:0]  cfg;
		logic [7:0]  div;
		logic [1:0]  ctl;
		logic [3:0]  flags;
		logic [15:0] txd;
		logic        go;
		spcc_fsm_t   st;
		logic [7:0]  divcnt;
		logic        sclk;
		logic        sclk_prev;
		logic [5:0]  edges;
		logic [3:0]  bitp;
		logic [15:0] txsh;
		logic [15:0] rxsh;
		logic        push;
		logic [15:0] pdata;
		logic        dout;
		logic        sclk_oe;
		logic        mosi_oe;
		logic        miso_oe;
		logic        irq;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        rdv;
	} spcc_regs_t;

	spcc_regs_t q_r;
	spcc_regs_t q_nxt;

	logic       mst;
	logic       en;
	logic       sel;
	logic       pha;
	logic       din;
	logic       setup;
	logic       access;
	logic       wr_ok;
	logic       busy;
	logic [5:0] last;
	logic       edge_ev;
	logic       active;
	logic       smp;
	logic       shf;
	logic [3:0] set;
	logic [3:0] clr;

	spcc_buf_if #(.W(SPCC_CHAR_W)) bif ();

	spcc_buf #(
		.W     (SPCC_CHAR_W),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.clk   (clk),
		.rst_n (rst_n),
		.bus   (bif.store)
	);

	function automatic logic spcc_hit(input logic [SPCC_AW-1:0] a);
		return a inside {SPCC_CFG_ADDR, SPCC_DIV_ADDR, SPCC_CTL_ADDR,
			SPCC_STAT_ADDR, SPCC_TX_ADDR, SPCC_RX_ADDR};
	endfunction

	assign mst    = q_r.ctl[SPCC_MST_BIT];
	assign en     = q_r.ctl[SPCC_EN_BIT];
	assign sel    = (ssel_i == q_r.cfg[SPCC_SAS_BIT]); // RULE_06
	assign pha    = q_r.cfg[SPCC_PHA_BIT];
	assign din    = mst ? miso_i : mosi_i;
	assign setup  = psel & ~penable;
	assign access = psel & penable & q_r.pready;
	assign wr_ok  = access & pwrite & ~q_r.pslverr;
	assign busy   = (q_r.st != SPCC_IDLE) | q_r.go;
	assign last   = q_r.cfg[SPCC_CHR_BIT] ? SPCC_EDGES_LONG : SPCC_EDGES_SHORT; // RULE_04

	// Master edges come from the divider, slave edges from the pin
	assign edge_ev = (q_r.st == SPCC_XFER) &
		(mst ? (q_r.divcnt == q_r.div) : (sclk_i != q_r.sclk_prev)); // RULE_08
	// Clock idles at the polarity level, so even-numbered edges are active
	assign active = ~q_r.edges[0]; // RULE_02
	assign smp    = pha ? ~active : active; // RULE_03
	assign shf    = pha ? (active & (q_r.edges != 6'h00)) : ~active; // RULE_03

	// Pop only a word that was present at setup, so the returned data matches
	assign bif.out_ready = access & ~pwrite & (paddr == SPCC_RX_ADDR) & q_r.rdv;
	assign bif.in_valid  = q_r.push;
	assign bif.in_data   = q_r.pdata;

	always_comb begin
		set = 4'h0;
		clr = 4'h0;
		q_nxt = q_r;
		q_nxt.push = 1'b0;
		q_nxt.pready = setup;
		q_nxt.sclk_prev = sclk_i;

		if (setup) begin
			q_nxt.pslverr = ~spcc_hit(paddr);
			q_nxt.rdv = bif.out_valid;
			case (paddr)
				SPCC_CFG_ADDR:  q_nxt.prdata = {24'h000000, q_r.cfg}; // RULE_05
				SPCC_DIV_ADDR:  q_nxt.prdata = {24'h000000, q_r.div};
				SPCC_CTL_ADDR:  q_nxt.prdata = {30'h00000000, q_r.ctl};
				SPCC_STAT_ADDR: q_nxt.prdata = {26'h0000000, bif.out_valid, busy, q_r.flags};
				SPCC_TX_ADDR:   q_nxt.prdata = {16'h0000, q_r.txd};
				SPCC_RX_ADDR:   q_nxt.prdata = {15'h0000, bif.out_valid, bif.out_data};
				default:        q_nxt.prdata = 32'h00000000;
			endcase
		end

		if (wr_ok) begin
			case (paddr)
				SPCC_CFG_ADDR: q_nxt.cfg = pwdata[7:0] & ~SPCC_CFG_RSVD; // RULE_05
				SPCC_DIV_ADDR: q_nxt.div = pwdata[7:0];
				SPCC_CTL_ADDR: q_nxt.ctl = pwdata[1:0];
				SPCC_STAT_ADDR: clr = pwdata[3:0];
				SPCC_TX_ADDR: begin
					// A write during a character would corrupt the shifter
					if (busy) begin
						set[SPCC_WRITE_COLLISION_FLAG_BIT] = 1'b1;
					end else begin
						q_nxt.txd = pwdata[15:0];
						q_nxt.go = mst & en;
					end
				end
				default: ;
			endcase
		end

		case (q_r.st)
			SPCC_IDLE: begin
				q_nxt.edges = 6'h00;
				q_nxt.divcnt = 8'h00;
				q_nxt.sclk = q_r.cfg[SPCC_POL_BIT]; // RULE_02
				q_nxt.bitp = q_r.cfg[SPCC_CHR_BIT] ? SPCC_MSB_LONG : SPCC_MSB_SHORT; // RULE_04
				// A full buffer holds the next master character back
				if (en && mst && q_r.go && !sel && bif.in_ready) begin
					q_nxt.go = 1'b0;
					q_nxt.txsh = q_r.txd;
					q_nxt.rxsh = 16'h0000;
					q_nxt.st = SPCC_XFER;
				end else if (en && !mst && sel) begin // RULE_06
					q_nxt.txsh = q_r.txd;
					q_nxt.rxsh = 16'h0000;
					q_nxt.st = SPCC_XFER;
				end
			end
			SPCC_XFER: begin
				if (mst) begin
					q_nxt.divcnt = edge_ev ? 8'h00 : q_r.divcnt + 8'h01; // RULE_08
				end
				if (edge_ev) begin
					if (mst) begin
						q_nxt.sclk = ~q_r.sclk; // RULE_08
					end
					if (smp) begin
						q_nxt.rxsh = {q_r.rxsh[14:0], din}; // RULE_03
					end
					if (shf) begin
						q_nxt.bitp = q_r.bitp - 4'h1;
					end
					q_nxt.edges = q_r.edges + 6'h01;
					if (q_nxt.edges == last) begin
						q_nxt.st = SPCC_DONE; // RULE_04
					end
				end
				// Deselect mid-character drops the partial word
				if (!en || (!mst && !sel)) begin
					q_nxt.st = SPCC_IDLE;
				end
			end
			SPCC_DONE: begin
				set[SPCC_DONE_BIT] = 1'b1;
				if (bif.in_ready) begin
					q_nxt.push = 1'b1;
					q_nxt.pdata = q_r.cfg[SPCC_CHR_BIT] ? q_r.rxsh
						: {8'h00, q_r.rxsh[7:0]}; // RULE_04
				end else begin
					// A slave cannot stall its master, so the word is lost
					set[SPCC_RECEIVE_OVERRUN_FLAG_BIT] = 1'b1;
				end
				q_nxt.st = SPCC_IDLE;
			end
			default: q_nxt.st = SPCC_IDLE;
		endcase

		// Another master selecting us while we drive the clock
		if (mst && en && sel && busy) begin
			set[SPCC_MODE_FAULT_FLAG_BIT] = 1'b1;
			q_nxt.go = 1'b0;
			q_nxt.st = SPCC_IDLE;
		end
		if (!en) begin
			q_nxt.go = 1'b0;
		end
		if (!mst) begin
			q_nxt.divcnt = 8'h00; // RULE_09
		end

		// Set wins over a clear in the same cycle
		q_nxt.flags = (q_r.flags & ~clr) | set;
		q_nxt.irq = q_nxt.cfg[SPCC_IE_BIT] & (|q_nxt.flags); // RULE_07 RULE_10
		q_nxt.dout = q_nxt.txsh[q_nxt.bitp];
		q_nxt.sclk_oe = q_nxt.ctl[SPCC_MST_BIT] & q_nxt.ctl[SPCC_EN_BIT]; // RULE_09
		q_nxt.mosi_oe = q_nxt.ctl[SPCC_MST_BIT] & q_nxt.ctl[SPCC_EN_BIT];
		q_nxt.miso_oe = ~q_nxt.ctl[SPCC_MST_BIT] & q_nxt.ctl[SPCC_EN_BIT]
			& (ssel_i == q_nxt.cfg[SPCC_SAS_BIT]); // RULE_06
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q_r <= '{st: SPCC_IDLE, default: '0}; // RULE_01
		end else begin
			q_r <= q_nxt;
		end
	end

	assign prdata   = q_r.prdata;
	assign pready   = q_r.pready;
	assign pslverr  = q_r.pslverr;
	assign sclk_o   = q_r.sclk;
	assign sclk_oe  = q_r.sclk_oe;
	assign mosi_o   = q_r.dout;
	assign mosi_oe  = q_r.mosi_oe;
	assign miso_o   = q_r.dout;
	assign miso_oe  = q_r.miso_oe;
	assign port_irq = q_r.irq;

	default clocking spcc_cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	cfg_reset_a: assert property ( // RULE_01
		$rose(rst_n) |-> (q_r.cfg == SPCC_CFG_RST) && (q_r.div == SPCC_DIV_RST))
		else $error("registers not cleared by reset");

	idle_level_a: assert property ( // RULE_02
		(q_r.st == SPCC_IDLE) && $past(q_r.st == SPCC_IDLE) && $stable(q_r.cfg)
		&& mst |-> sclk_o == q_r.cfg[SPCC_POL_BIT])
		else $error("idle clock level differs from polarity");

	rx_sample_a: assert property ( // RULE_03
		(edge_ev && smp) |=> q_r.rxsh[0] == $past(din))
		else $error("input bit not sampled on its edge");

	char_len_a: assert property ( // RULE_04
		(q_r.st == SPCC_DONE) |-> q_r.edges ==
		(q_r.cfg[SPCC_CHR_BIT] ? SPCC_EDGES_LONG : SPCC_EDGES_SHORT))
		else $error("character length wrong");

	rsvd_read_a: assert property ( // RULE_05
		(setup && paddr == SPCC_CFG_ADDR) |=> prdata[5:3] == 3'h0)
		else $error("reserved config bits read nonzero");

	ssel_start_a: assert property ( // RULE_06
		(q_r.st == SPCC_IDLE && en && !mst && sel && !wr_ok) |=> q_r.st == SPCC_XFER)
		else $error("slave did not start on active select");

	irq_off_a: assert property ( // RULE_07
		!q_r.cfg[SPCC_IE_BIT] |-> !port_irq)
		else $error("interrupt requested while disabled");

	irq_level_a: assert property ( // RULE_10
		port_irq == (q_r.cfg[SPCC_IE_BIT] && (|q_r.flags)))
		else $error("interrupt request does not match flags");

	half_period_a: assert property ( // RULE_08
		(q_r.st == SPCC_XFER && mst && en && !sel && !wr_ok && q_r.divcnt == q_r.div)
		|=> sclk_o != $past(sclk_o))
		else $error("master clock did not toggle at ratio");

	// The divider count clears one cycle after the mode bit falls, so its check waits a cycle
	div_slave_a: assert property ( // RULE_09
		!mst |-> !sclk_oe ##1 (q_r.divcnt == 8'h00))
		else $error("divider ran in slave mode");

	master_hold_a: assert property ( // RULE_08
		(q_r.st == SPCC_XFER && mst && (q_r.divcnt != q_r.div)) |=> sclk_o == $past(sclk_o))
		else $error("master clock moved between divider ends");

	slave_drive_a: assert property ( // RULE_06
		(en && !mst && sel && !wr_ok) |=> miso_oe && !mosi_oe)
		else $error("selected slave does not drive its output");

	flag_set_a: assert property ( // RULE_07
		(set != 4'h0) |=> (q_r.flags & $past(set)) == $past(set))
		else $error("status flag lost to a clear");

	tx_collide_a: assert property ( // RULE_07
		(wr_ok && paddr == SPCC_TX_ADDR && busy) |=> q_r.flags[SPCC_WRITE_COLLISION_FLAG_BIT])
		else $error("write during a character not flagged");

	// No wait states: ready never stands for two cycles
	pready_pulse_a: assert property (
		pready |=> !pready)
		else $error("ready stood longer than one cycle");

	unmapped_err_a: assert property (
		(setup && !spcc_hit(paddr)) |=> pready && pslverr && (prdata == 32'h00000000))
		else $error("unmapped access not refused");

	master_done_c: cover property (q_r.st == SPCC_DONE && mst);
	slave_done_c: cover property (q_r.st == SPCC_DONE && !mst);
	overrun_c: cover property (set[SPCC_RECEIVE_OVERRUN_FLAG_BIT]);
	collision_c: cover property (set[SPCC_WRITE_COLLISION_FLAG_BIT]);
	mode_fault_c: cover property (set[SPCC_MODE_FAULT_FLAG_BIT]);
endmodule // spcc_port

/* File: inc/spcc_pkg.sv */
package spcc_pkg;
	localparam int SPCC_AW = 12;
	localparam int SPCC_DW = 32;

	// Register indices; the byte address is four times the index
	localparam logic [7:0] SPCC_CFG_IDX  = 8'h0E;
	localparam logic [7:0] SPCC_DIV_IDX  = 8'h0F;
	localparam logic [7:0] SPCC_CTL_IDX  = 8'h10;
	localparam logic [7:0] SPCC_STAT_IDX = 8'h11;
	localparam logic [7:0] SPCC_TX_IDX   = 8'h12;
	localparam logic [7:0] SPCC_RX_IDX   = 8'h13;

	localparam logic [SPCC_AW-1:0] SPCC_CFG_ADDR  = {2'h0, SPCC_CFG_IDX, 2'h0};
	localparam logic [SPCC_AW-1:0] SPCC_DIV_ADDR  = {2'h0, SPCC_DIV_IDX, 2'h0};
	localparam logic [SPCC_AW-1:0] SPCC_CTL_ADDR  = {2'h0, SPCC_CTL_IDX, 2'h0};
	localparam logic [SPCC_AW-1:0] SPCC_STAT_ADDR = {2'h0, SPCC_STAT_IDX, 2'h0};
	localparam logic [SPCC_AW-1:0] SPCC_TX_ADDR   = {2'h0, SPCC_TX_IDX, 2'h0};
	localparam logic [SPCC_AW-1:0] SPCC_RX_ADDR   = {2'h0, SPCC_RX_IDX, 2'h0};

	// Configuration fields
	localparam int SPCC_POL_BIT = 0;
	localparam int SPCC_PHA_BIT = 1;
	localparam int SPCC_CHR_BIT = 2;
	localparam int SPCC_SAS_BIT = 6;
	localparam int SPCC_IE_BIT  = 7;
	localparam logic [7:0] SPCC_CFG_RSVD = 8'h38;
	localparam logic [7:0] SPCC_CFG_RST  = 8'h00;
	localparam logic [7:0] SPCC_DIV_RST  = 8'h00;

	// Control and status fields
	localparam int SPCC_EN_BIT   = 0;
	localparam int SPCC_MST_BIT  = 1;
	localparam int SPCC_MODE_FAULT_FLAG_BIT = 0;
	localparam int SPCC_WRITE_COLLISION_FLAG_BIT = 1;
	localparam int SPCC_RECEIVE_OVERRUN_FLAG_BIT = 2;
	localparam int SPCC_DONE_BIT = 3;

	// Clock edges per character and first bit index
	localparam logic [5:0] SPCC_EDGES_SHORT = 6'h10;
	localparam logic [5:0] SPCC_EDGES_LONG  = 6'h20;
	localparam logic [3:0] SPCC_MSB_SHORT   = 4'h7;
	localparam logic [3:0] SPCC_MSB_LONG    = 4'hF;
	localparam int SPCC_CHAR_W    = 16;
	localparam int SPCC_BUF_DEPTH = 2;

	typedef enum logic [2:0] {
		SPCC_IDLE = 3'h1,
		SPCC_XFER = 3'h2,
		SPCC_DONE = 3'h4
	} spcc_fsm_t;
endpackage

/* File: inc/spcc_buf_if.sv */
interface spcc_buf_if #(parameter int W = 16);
	logic [W-1:0] in_data;
	logic         in_valid;
	logic         in_ready;
	logic [W-1:0] out_data;
	logic         out_valid;
	logic         out_ready;

	modport filler (
		output in_data, in_valid, out_ready,
		input  in_ready, out_data, out_valid
	);
	modport store (
		input  in_data, in_valid, out_ready,
		output in_ready, out_data, out_valid
	);
endinterface

/* File: hdl/spcc_buf.sv */
module spcc_buf #(
	parameter int W     = 16,
	parameter int DEPTH = 2
) (
	input  wire logic    clk,
	input  wire logic    rst_n,
	spcc_buf_if.store    bus
);
	import spcc_pkg::*;

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("spcc_buf: DEPTH must be a power of two of at least two");
	end

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           rd;
		logic [AW-1:0]           wr;
		logic [CW-1:0]           cnt;
	} spcc_bufst_t;

	spcc_bufst_t q_r;
	spcc_bufst_t q_nxt;
	logic        push;
	logic        pop;

	assign bus.in_ready  = (q_r.cnt != CW'(DEPTH));
	assign bus.out_valid = (q_r.cnt != '0);
	assign bus.out_data  = q_r.mem[q_r.rd];
	assign push = bus.in_valid & bus.in_ready;
	assign pop  = bus.out_valid & bus.out_ready;

	always_comb begin
		q_nxt = q_r;
		if (push) begin
			q_nxt.mem[q_r.wr] = bus.in_data;
			q_nxt.wr = q_r.wr + 1'b1;
		end
		if (pop) begin
			q_nxt.rd = q_r.rd + 1'b1;
		end
		case ({push, pop})
			2'h2: q_nxt.cnt = q_r.cnt + 1'b1;
			2'h1: q_nxt.cnt = q_r.cnt - 1'b1;
			default: q_nxt.cnt = q_r.cnt;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	cnt_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
		q_r.cnt <= CW'(DEPTH))
		else $error("buffer count above depth");
	full_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!bus.in_ready && !bus.out_ready) |=> q_r.cnt == $past(q_r.cnt))
		else $error("full buffer took a word");
endmodule // spcc_buf

/* File: bench/spcc_peer_model.sv */
module spcc_peer_model (
	input  wire logic        sclk,
	input  wire logic        mosi,
	input  wire logic        pol,
	input  wire logic        pha,
	input  wire logic        chr,
	input  wire logic        load,
	input  wire logic [15:0] tx,
	output      logic        miso,
	output      logic [15:0] rx
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] sh;

	// Refills with the inverse so a stale bit never reads as a match
	task automatic shout();
		miso = chr ? sh[15] : sh[7];
		sh = {sh[14:0], ~miso};
	endtask

	initial begin
		miso = 1'b0;
		rx = 16'h0000;
		sh = 16'h0000;
	end

	always @(posedge load) begin
		sh = tx;
		rx = 16'h0000;
		if (!pha)
			shout();
	end

	always @(sclk) begin
		if ((sclk !== pol) == !pha)
			rx = {rx[14:0], mosi};
		else
			shout();
	end
endmodule // spcc_peer_model

/* File: bench/testbench.sv */
module testbench;
	import spcc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic			clk, rst_n, psel, penable, pwrite, sclk_i, mosi_i, ssel_i, ld, sclk_q;
	logic			pready, pslverr, sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe;
	logic			port_irq, erv, miso_p;
	logic [SPCC_AW-1:0]	paddr;
	logic [SPCC_DW-1:0]	pwdata, prdata, rdv;
	logic [15:0]		ptx, prx, dat, msk;
	logic [7:0]		cfg, dv, so;
	int			n_errors, num_checks, gap, cnt, n_edg, k;
	int			q[$];

	spcc_port dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sclk_i(sclk_i), .sclk_o(sclk_o),
		.sclk_oe(sclk_oe), .mosi_i(mosi_i), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
		.miso_i(miso_p), .miso_o(miso_o), .miso_oe(miso_oe), .ssel_i(ssel_i),
		.port_irq(port_irq));

	spcc_peer_model peer (.sclk(sclk_o), .mosi(mosi_o), .pol(cfg[SPCC_POL_BIT]),
		.pha(cfg[SPCC_PHA_BIT]), .chr(cfg[SPCC_CHR_BIT]), .load(ld), .tx(ptx),
		.miso(miso_p), .rx(prx));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Sampled before the edge lands, so gap is the clocks between toggles
	always @(posedge clk) begin
		if (sclk_o !== sclk_q) begin
			gap = cnt;
			cnt = 1;
			n_edg++;
		end else
			cnt++;
		sclk_q = sclk_o;
	end

	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic pop_rx();
		apb(1'b0, SPCC_RX_ADDR, 32'h0);
		chk("rxdata", rdv, {15'h0000, 1'b1, 16'(q.pop_front())});
	endtask

	task automatic start(input logic [7:0] c);
		cfg = c;
		msk = c[SPCC_CHR_BIT] ? 16'hFFFF : 16'h00FF;
		dv = 8'($urandom_range(3));
		dat = 16'($urandom) & msk;
		ssel_i <= ~c[SPCC_SAS_BIT];
		apb(1'b1, SPCC_CFG_ADDR, {24'h0, c});
		apb(1'b0, SPCC_CFG_ADDR, 32'h0);
		chk("config", rdv, {24'h0, c & ~SPCC_CFG_RSVD});
		apb(1'b1, SPCC_DIV_ADDR, {24'h0, dv});
		apb(1'b0, SPCC_DIV_ADDR, 32'h0);
		chk("divider", rdv, {24'h0, dv});
		ptx = 16'($urandom);
		ld <= 1'b1;
		@(posedge clk);
		ld <= 1'b0;
		apb(1'b1, SPCC_TX_ADDR, {16'h0, dat});
		q.push_back(int'(ptx & msk));
	endtask

	task automatic finish_xfer();
		k = 0;
		do begin
			apb(1'b0, SPCC_STAT_ADDR, 32'h0);
			k++;
		end while (rdv[SPCC_DONE_BIT] !== 1'b1 && k < 500);
		chk("done_flag", rdv[SPCC_DONE_BIT], 1'b1);
		chk("peer_rx", {16'h0, prx & msk}, {16'h0, dat});
		chk("half_period", gap, dv + 1);
		chk("idle_clock", sclk_o, cfg[SPCC_POL_BIT]);
		chk("irq_set", port_irq, cfg[SPCC_IE_BIT]);
		chk("drive_oe", {sclk_oe, mosi_oe, miso_oe}, 3'h6);
		apb(1'b1, SPCC_STAT_ADDR, 32'hF);
		repeat (2) @(posedge clk);
		chk("irq_clear", port_irq, 1'b0);
	endtask

	task automatic sframe(input logic [7:0] b);
		repeat (4) @(posedge clk);
		for (int j = 7; j >= 0; j--) begin
			mosi_i <= b[j];
			repeat (4) @(posedge clk);
			// Only a driven pin counts, so an unselected slave reads as zero
			so = {so[6:0], miso_o & miso_oe};
			sclk_i <= 1'b1;
			repeat (4) @(posedge clk);
			sclk_i <= 1'b0;
		end
		mosi_i <= ~b[0];
		repeat (8) @(posedge clk);
	endtask

	initial begin
		#2000000;
		n_errors++;
		end_sim();
	end

	initial begin
		{rst_n, psel, penable, pwrite, sclk_i, mosi_i, ld, sclk_q} = 8'h00;
		{paddr, pwdata, ptx, cfg, dv} = '0;
		ssel_i = 1'b1;
		k = $urandom(78);
		repeat (12) @(posedge clk);
		chk("irq_in_reset", port_irq, 1'b0);
		rst_n <= 1'b1;
		@(posedge clk);
		apb(1'b0, SPCC_CFG_ADDR, 32'h0);
		chk("config_reset", rdv, 32'h0);
		apb(1'b0, SPCC_DIV_ADDR, 32'h0);
		chk("divider_reset", rdv, 32'h0);
		apb(1'b0, 12'h100, 32'h0);
		chk("unmapped_err", erv, 1'b1);
		chk("unmapped_data", rdv, 32'h0);
		apb(1'b1, SPCC_CTL_ADDR, 32'h3);
		for (int i = 0; i < 8; i++) begin
			dv = 8'($urandom);
			dv[2:0] = 3'(i);
			dv[SPCC_IE_BIT] = i[0];
			start(dv);
			finish_xfer();
			if (q.size() == 2)
				pop_rx();
		end
		start(8'($urandom));
		finish_xfer();
		// Buffer now full: the next character must wait for a read
		start(8'($urandom));
		k = n_edg;
		repeat (40) @(posedge clk);
		chk("stall_edges", n_edg, k);
		pop_rx();
		finish_xfer();
		pop_rx();
		pop_rx();
		ssel_i <= 1'b0;
		cfg = 8'h40;
		apb(1'b1, SPCC_CFG_ADDR, 32'h40);
		apb(1'b1, SPCC_DIV_ADDR, 32'hFF);
		apb(1'b1, SPCC_CTL_ADDR, 32'h1);
		apb(1'b1, SPCC_TX_ADDR, {16'h0, ptx});
		k = n_edg;
		for (int f = 0; f < 2; f++) begin
			dat = 16'($urandom_range(255));
			ssel_i <= (f == 0);
			sframe(dat[7:0]);
			chk("slave_tx", so, (f == 0) ? ptx[7:0] : 8'h00);
			if (f == 0)
				q.push_back(int'(dat));
		end
		chk("slave_clock_oe", {sclk_oe, mosi_oe}, 2'h0);
		chk("slave_edges", n_edg, k);
		pop_rx();
		apb(1'b0, SPCC_RX_ADDR, 32'h0);
		chk("rx_empty", rdv[16], 1'b0);
		// Second reset in mid-run with nonzero configuration and divider
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		apb(1'b0, SPCC_CFG_ADDR, 32'h0);
		chk("config_rereset", rdv, 32'h0);
		apb(1'b0, SPCC_DIV_ADDR, 32'h0);
		chk("divider_rereset", rdv, 32'h0);
		end_sim();
	end
endmodule // testbench
